// [include/intc_pkg.sv]
// Constants, types and vector decode for the vectored interrupt arbiter.
// Assumes a single core clock domain; all users refer to names as intc_pkg::name.
package intc_pkg;
	localparam int NUM_MASKABLE = 22;
	// Source indices in the maskable vector, equal to the default order
	localparam int IDX_WDT = 0;
	localparam int IDX_PIN0 = 1;
	localparam int IDX_KEY = 7;
	localparam int IDX_RX_ERR = 8;
	localparam int IDX_RX_DONE = 9;
	localparam int IDX_TX_DONE = 10;
	localparam int IDX_CSER_A = 11;
	localparam int IDX_CSER_B = 12;
	localparam int IDX_WATCH_INT = 13;
	localparam int IDX_WIDE_CH0 = 14;
	localparam int IDX_WIDE_CH1 = 15;
	localparam int IDX_TIMER4 = 16;
	localparam int IDX_BYTE_A = 17;
	localparam int IDX_ADC = 20;
	localparam int IDX_WATCH_OVF = 21;
	// Winner codes beyond the maskable range
	localparam logic [4:0] ID_NMI = 5'h16;
	localparam logic [4:0] ID_BRK = 5'h17;
	// Vector table addresses
	localparam logic [15:0] VEC_NMI = 16'h0004;
	localparam logic [15:0] VEC_WDT_INTERVAL = 16'h0004;
	localparam logic [15:0] VEC_FIRST_PIN = 16'h0006;
	localparam logic [15:0] VEC_BRK = 16'h003e;
	// Register byte offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_PRIO = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// Reset values
	localparam logic [21:0] RST_FLAGS = 22'h000000;
	localparam logic [21:0] RST_MASK = 22'h3fffff;
	localparam logic [21:0] RST_PRIO = 22'h3fffff;
	localparam logic [7:0] RST_KEY_PORT = 8'hff;
	typedef enum logic [3:0] {
		SVC_IDLE = 4'b0001,
		SVC_LOW = 4'b0010,
		SVC_HIGH = 4'b0100,
		SVC_NESTED = 4'b1000
	} svc_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_t;
	// Vector address of a winner code
	function automatic logic [15:0] vector_of(input logic [4:0] id);
		logic [4:0] rel;
		rel = 5'(id - 5'h01);
		if (id == ID_NMI)
			return VEC_NMI;
		if (id == ID_BRK)
			return VEC_BRK;
		if (id == 5'h00)
			return VEC_WDT_INTERVAL;
		return 16'(VEC_FIRST_PIN + {10'h000, rel, 1'b0});
	endfunction : vector_of
endpackage : intc_pkg

// [include/arb_if.sv]
// Carrier between the arbiter top and its priority picker.
// Assumes both ends run on the same clock and synchronised reset.
`timescale 1ns/100ps
interface arb_if;
	logic clk;
	logic rst_n;
	logic [21:0] pending;
	logic [21:0] low_group;
	logic allow_high;
	logic allow_low;
	logic valid;
	logic win_high;
	logic [4:0] index;
	modport ctrl (output clk, rst_n, pending, low_group, allow_high, allow_low,
		input valid, win_high, index);
	modport pick (input clk, rst_n, pending, low_group, allow_high, allow_low,
		output valid, win_high, index);
endinterface : arb_if

// [src/arb_pick.sv]
// Group-then-default-order picker for the maskable requests.
// Assumes pending is already masked; lower index means higher default order.
`timescale 1ns/100ps
module arb_pick (
	arb_if.pick a
);
	// Returns {found, index of lowest set bit}
	function automatic logic [5:0] first_set(input logic [21:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = intc_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
			if (v[i])
				r = {1'b1, 5'(i)};
		end
		return r;
	endfunction : first_set

	// Candidates per group; high group is searched first
	wire [21:0] hi_cand = a.pending & ~a.low_group & {22{a.allow_high}};
	wire [21:0] lo_cand = a.pending & a.low_group & {22{a.allow_low}};
	wire [5:0] hi_pick = first_set(hi_cand);
	wire [5:0] lo_pick = first_set(lo_cand);
	assign a.valid = hi_pick[5] | lo_pick[5];
	assign a.win_high = hi_pick[5]; // RULE21
	assign a.index = hi_pick[5] ? hi_pick[4:0] : lo_pick[4:0]; // RULE21

	// Nothing of higher default order may stand in the winning group
	a_default_order: assert property (@(posedge a.clk) disable iff (!a.rst_n) // RULE7
		a.valid |-> (((a.win_high ? hi_cand : lo_cand)
		& 22'((22'h000001 << a.index) - 22'h000001)) == 22'h000000))
		else $error("lower-order source won over higher-order one");
endmodule : arb_pick

// [src/vectored_interrupt_arbiter.sv]
// Interrupt arbitration and vectoring for the core, with Avalon-MM registers.
// Assumes source strobes and core handshakes are synchronous to clk.
`timescale 1ns/100ps

// Functional notes
// (RULE1) Non-maskable request is taken even when disabled and outranks all.
// (RULE2) Any non-maskable or maskable request raises standby release.
// (RULE3) Watchdog overflow in mode 1 is the non-maskable request at 0004H.
// (RULE4) Watchdog overflow in interval mode is maskable, default order 0.
// (RULE5) Maskable requests are masked per source and split by priority flag.
// (RULE6) A high group request may nest over a low group service routine.
// (RULE7) Same-group simultaneous requests resolve by default order 0 to 21.
// (RULE8) Maskable set is seven external and fifteen internal requests.
// (RULE9) Software break vectors to 003EH, even when disabled, no priority.
// (RULE10) Six pin edge requests take orders 1 to 6, vectors 0006H to 0010H.
// (RULE11) Port 4 falling edge raises key return request, order 7, 0012H.
// (RULE12) Async serial error, receive, transmit at 0014H, 0016H, 0018H.
// (RULE13) Clocked serial units A and B vector to 001AH and 001CH.
// (RULE14) Watch timer interval at 001EH, overflow order 21 at 002EH.
// (RULE15) Wide timer channel 0 fires on compare 0 match or capture edge.
// (RULE16) Wide timer channel 1 fires on compare 1 match or other capture edge.
// (RULE17) Timer four request at 0024H only in clear-and-start mode.
// (RULE18) Byte timers A, B, C vector to 0026H, 0028H, 002AH.
// (RULE19) Conversion done is maskable, order 20, vector 002CH.
// (RULE20) Acknowledge clears the winning source flag before service starts.
// (RULE21) When enabled, pick high group first, then default order; show vector.
module vectored_interrupt_arbiter (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic int_enable,
	input wire logic int_ack,
	input wire logic int_return,
	input wire logic software_break_instr,
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic standby_release,
	input wire logic watchdog_irq,
	input wire logic [5:0] pin_edge_irq,
	input wire logic [7:0] key_port,
	input wire logic async_rx_error_irq,
	input wire logic async_rx_done_irq,
	input wire logic async_tx_done_irq,
	input wire logic clocked_serial_a_irq,
	input wire logic clocked_serial_b_irq,
	input wire logic watch_interval_irq,
	input wire logic watch_overflow_irq,
	input wire logic wide_compare_0_match,
	input wire logic wide_compare_1_match,
	input wire logic capture_input_a_edge,
	input wire logic capture_input_b_edge,
	input wire logic wide_compare_0_capture,
	input wire logic wide_compare_1_capture,
	input wire logic timer_four_match,
	input wire logic timer_four_clear_start,
	input wire logic [2:0] byte_timer_match,
	input wire logic conversion_done_irq
);
	logic rst_meta;
	logic rst_n;
	logic [21:0] flags;
	logic [21:0] mask;
	logic [21:0] prio_low;
	logic wdt_interval;
	logic nmi_pend;
	logic brk_pend;
	logic [7:0] key_prev;
	logic [4:0] win_id;
	logic win_valid;
	logic win_high;
	logic ack_hold;
	intc_pkg::svc_t svc;
	intc_pkg::svc_t next_svc;
	intc_pkg::bus_t bus;
	arb_if arb ();

	// Reset release through two stages; assertion stays asynchronous
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Key return port history, idle high so no false edge after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			key_prev <= intc_pkg::RST_KEY_PORT;
		else
			key_prev <= key_port;
	end
	wire key_fall = |(key_prev & ~key_port); // RULE11

	// Source strobes mapped onto the default order
	wire [21:0] src_event;
	assign src_event[intc_pkg::IDX_WDT] = watchdog_irq & wdt_interval; // RULE4
	assign src_event[intc_pkg::IDX_PIN0 +: 6] = pin_edge_irq; // RULE10
	assign src_event[intc_pkg::IDX_KEY] = key_fall; // RULE11
	assign src_event[intc_pkg::IDX_RX_ERR] = async_rx_error_irq; // RULE12
	assign src_event[intc_pkg::IDX_RX_DONE] = async_rx_done_irq; // RULE12
	assign src_event[intc_pkg::IDX_TX_DONE] = async_tx_done_irq; // RULE12
	assign src_event[intc_pkg::IDX_CSER_A] = clocked_serial_a_irq; // RULE13
	assign src_event[intc_pkg::IDX_CSER_B] = clocked_serial_b_irq; // RULE13
	assign src_event[intc_pkg::IDX_WATCH_INT] = watch_interval_irq; // RULE14
	assign src_event[intc_pkg::IDX_WATCH_OVF] = watch_overflow_irq; // RULE14
	// Channel 0 takes the second capture input; the pair is crossed
	assign src_event[intc_pkg::IDX_WIDE_CH0] = wide_compare_0_capture ?
		capture_input_b_edge : wide_compare_0_match; // RULE15
	assign src_event[intc_pkg::IDX_WIDE_CH1] = wide_compare_1_capture ?
		capture_input_a_edge : wide_compare_1_match; // RULE16
	assign src_event[intc_pkg::IDX_TIMER4] = timer_four_match & timer_four_clear_start; // RULE17
	assign src_event[intc_pkg::IDX_BYTE_A +: 3] = byte_timer_match; // RULE18
	assign src_event[intc_pkg::IDX_ADC] = conversion_done_irq; // RULE19
	// Seven external and fifteen internal bits fill the vector exactly (RULE8)
	wire nmi_event = watchdog_irq & ~wdt_interval; // RULE3

	// Bus decode; one wait cycle, the answer edge commits
	wire bus_req = avs_read | avs_write;
	wire bus_commit = bus_req & (bus == intc_pkg::BUS_ANSWER);
	wire wr_commit = avs_write & bus_commit;
	wire wr_flags = wr_commit & (avs_address == intc_pkg::OFS_FLAGS);
	wire wr_mask = wr_commit & (avs_address == intc_pkg::OFS_MASK);
	wire wr_prio = wr_commit & (avs_address == intc_pkg::OFS_PRIO);
	wire wr_ctrl = wr_commit & (avs_address == intc_pkg::OFS_CTRL);
	assign avs_waitrequest = bus_req & (bus == intc_pkg::BUS_IDLE);

	// Core handshake; the cycle after an acknowledge is held off
	assign irq_req = win_valid & ~ack_hold;
	wire take = int_ack & irq_req;
	wire take_mask = take & (win_id < intc_pkg::ID_NMI);
	wire [21:0] ack_clear = take_mask ? 22'(22'h000001 << win_id) : 22'h000000;

	// Flags: a source strobe wins over both software and acknowledge clears
	wire [21:0] next_flags = wr_flags ? (avs_writedata[21:0] | src_event)
		: ((flags & ~ack_clear) | src_event); // RULE20
	wire next_nmi = nmi_event | (nmi_pend & ~(take & (win_id == intc_pkg::ID_NMI)));
	wire next_brk = software_break_instr | (brk_pend & ~(take & (win_id == intc_pkg::ID_BRK)));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= intc_pkg::RST_FLAGS;
			nmi_pend <= 1'b0;
			brk_pend <= 1'b0;
			standby_release <= 1'b0;
		end else begin
			flags <= next_flags;
			nmi_pend <= next_nmi;
			brk_pend <= next_brk; // RULE9
			standby_release <= (|next_flags) | next_nmi; // RULE2
		end
	end

	// Software settings: mask, group and watchdog routing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= intc_pkg::RST_MASK;
			prio_low <= intc_pkg::RST_PRIO;
			wdt_interval <= 1'b0;
		end else begin
			if (wr_mask)
				mask <= avs_writedata[21:0];
			if (wr_prio)
				prio_low <= avs_writedata[21:0];
			if (wr_ctrl)
				wdt_interval <= avs_writedata[0];
		end
	end

	// Picker inputs; nesting depth decides which groups may still win
	assign arb.clk = clk;
	assign arb.rst_n = rst_n;
	assign arb.pending = flags & ~mask; // RULE5
	assign arb.low_group = prio_low; // RULE5
	assign arb.allow_high = int_enable & ((svc == intc_pkg::SVC_IDLE)
		| (svc == intc_pkg::SVC_LOW)); // RULE6
	assign arb.allow_low = int_enable & (svc == intc_pkg::SVC_IDLE);
	arb_pick u_pick (
		.a(arb.pick)
	);

	// Non-maskable first, then the break, then the maskable winner
	wire [4:0] next_win_id = nmi_pend ? intc_pkg::ID_NMI
		: brk_pend ? intc_pkg::ID_BRK : arb.index; // RULE1
	wire next_win_valid = nmi_pend | brk_pend | arb.valid; // RULE1
	wire next_win_high = ~nmi_pend & ~brk_pend & arb.win_high;

	// Winner and its vector are registered so the core sees stable data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_id <= 5'h00;
			win_valid <= 1'b0;
			win_high <= 1'b0;
			irq_vector <= 16'h0000;
			ack_hold <= 1'b0;
		end else begin
			win_id <= next_win_id;
			win_valid <= next_win_valid;
			win_high <= next_win_high;
			irq_vector <= intc_pkg::vector_of(next_win_id); // RULE10
			ack_hold <= take;
		end
	end

	// Service level tracking; the stale winner after an ack is why irq_req drops
	always_comb begin
		next_svc = svc;
		unique case (svc)
			intc_pkg::SVC_IDLE: begin
				if (take_mask)
					next_svc = win_high ? intc_pkg::SVC_HIGH : intc_pkg::SVC_LOW;
			end
			intc_pkg::SVC_LOW: begin
				if (take_mask)
					next_svc = intc_pkg::SVC_NESTED; // RULE6
				else if (int_return)
					next_svc = intc_pkg::SVC_IDLE;
			end
			intc_pkg::SVC_HIGH: begin
				if (int_return)
					next_svc = intc_pkg::SVC_IDLE;
			end
			intc_pkg::SVC_NESTED: begin
				if (int_return)
					next_svc = intc_pkg::SVC_LOW;
			end
			default: next_svc = intc_pkg::SVC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			svc <= intc_pkg::SVC_IDLE;
		else
			svc <= next_svc;
	end

	// Read mux; unmapped addresses read zero and ignore writes
	wire [31:0] status_word = {18'h00000, svc, brk_pend, nmi_pend,
		irq_req, win_high, win_id, 1'b0};
	wire [31:0] rd_value =
		(avs_address == intc_pkg::OFS_FLAGS) ? {10'h000, flags} :
		(avs_address == intc_pkg::OFS_MASK) ? {10'h000, mask} :
		(avs_address == intc_pkg::OFS_PRIO) ? {10'h000, prio_low} :
		(avs_address == intc_pkg::OFS_CTRL) ? {31'h00000000, wdt_interval} :
		(avs_address == intc_pkg::OFS_STATUS) ? status_word : 32'h00000000;

	// Bus sequencer: data is captured at the edge entering the answer cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus <= intc_pkg::BUS_IDLE;
			avs_readdata <= 32'h00000000;
		end else begin
			unique case (bus)
				intc_pkg::BUS_IDLE: begin
					if (bus_req) begin
						bus <= intc_pkg::BUS_ANSWER;
						avs_readdata <= rd_value;
					end
				end
				intc_pkg::BUS_ANSWER: bus <= intc_pkg::BUS_IDLE;
				default: bus <= intc_pkg::BUS_IDLE;
			endcase
		end
	end

	// Checks on the arbitration and acknowledge behaviour
	sequence s_ack_mask;
		take_mask && !wr_flags && !src_event[win_id];
	endsequence
	sequence s_wdt_nmi;
		watchdog_irq && !wdt_interval;
	endsequence

	a_nmi_wins_all: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
		nmi_pend |=> (win_valid && win_id == intc_pkg::ID_NMI && irq_vector == intc_pkg::VEC_NMI))
		else $error("pending non-maskable request did not win");
	a_standby_wakes: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
		((|src_event) || nmi_event) |=> standby_release)
		else $error("request did not raise standby release");
	a_wdt_nmi_route: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
		s_wdt_nmi |=> nmi_pend ##1 (irq_vector == 16'h0004))
		else $error("watchdog mode 1 overflow not vectored as non-maskable");
	a_wdt_maskable: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
		(watchdog_irq && wdt_interval) |=> (flags[0] && !$past(nmi_event)))
		else $error("interval watchdog overflow not maskable");
	a_mask_silences: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
		((flags & ~mask) == 22'h000000 && !nmi_pend && !brk_pend) |=> !win_valid)
		else $error("masked request produced a winner");
	a_high_nests: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
		(svc == intc_pkg::SVC_LOW && arb.valid && !nmi_pend && !brk_pend)
		|=> (win_high && win_valid))
		else $error("low service routine blocked a high request");
	a_brk_vector: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		(brk_pend && !nmi_pend) |=> (irq_vector == 16'h003e && win_valid))
		else $error("software break not vectored");
	a_ack_clears: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
		s_ack_mask |=> (flags[$past(win_id)] == 1'b0 && !irq_req))
		else $error("acknowledged flag not cleared");
	// Maskable table is 0004H plus two bytes per order, worked out apart from the decode function
	a_vector_match: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		(irq_req && win_id < intc_pkg::ID_NMI) |-> (irq_vector == ({10'h000, win_id, 1'b0} + 16'h0004)))
		else $error("vector does not match winner");
	a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
		(bus_req && bus == intc_pkg::BUS_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");

	// Source wiring: a strobe must land in its own flag on the next edge, whatever else happens
	sequence s_any_event;
		|src_event;
	endsequence
	a_event_lands: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
		s_any_event |=> ((flags & $past(src_event)) == $past(src_event)))
		else $error("source event did not set its flag");
	a_pin_order: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
		(pin_edge_irq != 6'h00) |=> ((flags[intc_pkg::IDX_PIN0 +: 6] & $past(pin_edge_irq)) == $past(pin_edge_irq)))
		else $error("pin edge request not flagged at its order");
	a_key_fall: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
		(|(key_prev & ~key_port)) |=> flags[intc_pkg::IDX_KEY])
		else $error("port falling edge not flagged");
	a_async_error: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
		async_rx_error_irq |=> flags[intc_pkg::IDX_RX_ERR])
		else $error("receive error not flagged");
	a_watch_overflow: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
		watch_overflow_irq |=> flags[intc_pkg::IDX_WATCH_OVF])
		else $error("watch overflow not flagged at lowest order");
	// Capture pairs are crossed, so a wiring slip shows up here first
	a_capture_ch0: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
		(wide_compare_0_capture && capture_input_b_edge) |=> flags[intc_pkg::IDX_WIDE_CH0])
		else $error("channel 0 capture edge not flagged");
	a_capture_ch1: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
		(wide_compare_1_capture && capture_input_a_edge) |=> flags[intc_pkg::IDX_WIDE_CH1])
		else $error("channel 1 capture edge not flagged");
	a_timer4_gated: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
		(timer_four_match && !timer_four_clear_start && !flags[intc_pkg::IDX_TIMER4] && !wr_flags)
		|=> !flags[intc_pkg::IDX_TIMER4])
		else $error("timer four match flagged outside clear-and-start");
	a_byte_timers: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
		(byte_timer_match != 3'h0)
		|=> ((flags[intc_pkg::IDX_BYTE_A +: 3] & $past(byte_timer_match)) == $past(byte_timer_match)))
		else $error("byte timer match not flagged");
	a_conversion_done: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
		conversion_done_irq |=> flags[intc_pkg::IDX_ADC])
		else $error("conversion done not flagged");
endmodule : vectored_interrupt_arbiter

// [verif/core_model.sv]
// Behavioural model of the processor core side of the arbiter.
// Assumes irq_req and irq_vector are settled before each rising clk edge.
`timescale 1ns/100ps
module core_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic [2:0] ack_delay,
	input wire logic auto_ret,
	input wire logic extra_ret,
	output logic int_ack,
	output logic int_return,
	output logic taken_valid,
	output logic [15:0] taken_vector
);
	logic [2:0] wait_cnt;
	logic [2:0] ret_cnt;
	logic ret_pulse;
	// Bench may close a service by hand on top of the automatic return
	assign int_return = ret_pulse | extra_ret;
	// Acknowledge after a chosen delay, record the vector at the take edge
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_ack <= 1'b0;
			wait_cnt <= 3'h0;
			ret_cnt <= 3'h0;
			ret_pulse <= 1'b0;
			taken_valid <= 1'b0;
			taken_vector <= 16'h0000;
		end else begin
			taken_valid <= 1'b0;
			ret_pulse <= (ret_cnt == 3'h1);
			if (ret_cnt != 3'h0)
				ret_cnt <= ret_cnt - 3'h1;
			if (int_ack && irq_req) begin
				int_ack <= 1'b0;
				wait_cnt <= 3'h0;
				taken_valid <= 1'b1;
				taken_vector <= irq_vector;
				ret_cnt <= auto_ret ? 3'h3 : 3'h0;
			end else if (irq_req && !int_ack) begin
				// Raising ack only while a request stands keeps the take clean
				if (wait_cnt >= ack_delay)
					int_ack <= 1'b1;
				else
					wait_cnt <= wait_cnt + 3'h1;
			end
		end
	end
endmodule : core_model

// [verif/vectored_interrupt_arbiter_tb_top.sv]
// Self-checking bench: drives sources and registers, a core model takes vectors.
// Assumes the arbiter answers each bus request with one wait cycle.
`timescale 1ns/100ps
module vectored_interrupt_arbiter_tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic int_enable = 1'b0;
	logic int_ack, int_return, irq_req, standby_release, taken_valid;
	logic [15:0] irq_vector, taken_vector;
	logic [24:0] src = 25'h0000000;
	logic [3:0] cfg = 4'h0;
	logic [7:0] keys = 8'hff;
	logic [2:0] ack_delay = 3'h0;
	logic auto_ret = 1'b1;
	logic extra_ret = 1'b0;
	logic [15:0] exp_q[$];
	logic [31:0] rd;
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 32'h14bac200;
	always #2.5 clk = ~clk;
	vectored_interrupt_arbiter i_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_enable(int_enable),
		.int_ack(int_ack), .int_return(int_return), .software_break_instr(src[24]), .irq_req(irq_req),
		.irq_vector(irq_vector), .standby_release(standby_release), .watchdog_irq(src[0]),
		.pin_edge_irq(src[6:1]), .key_port(keys), .async_rx_error_irq(src[8]),
		.async_rx_done_irq(src[9]), .async_tx_done_irq(src[10]), .clocked_serial_a_irq(src[11]),
		.clocked_serial_b_irq(src[12]), .watch_interval_irq(src[13]), .watch_overflow_irq(src[21]),
		.wide_compare_0_match(src[14]), .wide_compare_1_match(src[15]), .capture_input_a_edge(src[22]),
		.capture_input_b_edge(src[23]), .wide_compare_0_capture(cfg[0]), .wide_compare_1_capture(cfg[1]),
		.timer_four_match(src[16]), .timer_four_clear_start(cfg[2]), .byte_timer_match(src[19:17]),
		.conversion_done_irq(src[20]));
	core_model i_core (.clk(clk), .resetn(resetn), .irq_req(irq_req), .irq_vector(irq_vector),
		.ack_delay(ack_delay), .auto_ret(auto_ret), .extra_ret(extra_ret), .int_ack(int_ack),
		.int_return(int_return), .taken_valid(taken_valid), .taken_vector(taken_vector));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %0s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// Bus cycles hold the request until waitrequest is seen low at an edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_rd
	task automatic pulse(input logic [24:0] m);
		@(posedge clk);
		src <= m;
		// Bit 7 stands for the key port: one randomly chosen line falls
		keys <= m[7] ? ~(8'h01 << ($unsigned($random(seed)) % 8)) : 8'hff;
		ack_delay <= 3'($unsigned($random(seed)) % 4);
		@(posedge clk);
		src <= 25'h0000000;
		keys <= 8'hff;
	endtask : pulse
	// Wait, bounded, until the core has taken every expected vector
	task automatic drain(input string name);
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		check("queue left", exp_q.size(), 0);
		repeat (6) @(posedge clk);
		$display("test %0s done", name);
	endtask : drain
	// Each taken vector is matched against the oldest note
	always @(posedge clk) begin
		if (taken_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("unexpected take", {16'h0000, taken_vector}, 32'hffffffff);
			else
				check("vector", {16'h0000, taken_vector}, {16'h0000, exp_q.pop_front()});
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		bus_rd(intc_pkg::OFS_MASK, rd); check("mask", rd, 32'h003fffff);
		bus_rd(intc_pkg::OFS_PRIO, rd); check("prio", rd, 32'h003fffff);
		bus_rd(intc_pkg::OFS_FLAGS, rd); check("flags", rd, 32'h00000000);
		bus_rd(8'h14, rd); check("unmapped", rd, 32'h00000000);
		// Random flag pattern while all sources are masked
		avs_writedata <= 32'h00000000;
		bus_wr(intc_pkg::OFS_FLAGS, $random(seed) & 32'h003fffff);
		bus_rd(intc_pkg::OFS_FLAGS, rd); check("flags rw", rd, avs_writedata);
		bus_wr(intc_pkg::OFS_FLAGS, 32'h00000000);
		// Enabled, so only the mask can keep the request quiet
		int_enable <= 1'b1;
		pulse(25'h1 << 9);
		repeat (3) @(posedge clk);
		check("standby", standby_release, 1'b1);
		check("masked req", irq_req, 1'b0);
		int_enable <= 1'b0;
		bus_wr(intc_pkg::OFS_FLAGS, 32'h00000000);
		repeat (3) @(posedge clk);
		check("standby off", standby_release, 1'b0);
		// Watchdog as non-maskable plus break, both while disabled
		exp_q.push_back(intc_pkg::VEC_NMI);
		exp_q.push_back(intc_pkg::VEC_BRK);
		pulse(25'h1000001);
		drain("nmi and break");
		bus_wr(intc_pkg::OFS_CTRL, 32'h00000001);
		bus_wr(intc_pkg::OFS_MASK, 32'h00000000);
		pulse(25'h1);
		bus_rd(intc_pkg::OFS_FLAGS, rd); check("wdt flag", rd, 32'h00000001);
		int_enable <= 1'b1;
		exp_q.push_back(intc_pkg::VEC_WDT_INTERVAL);
		drain("interval watchdog");
		// Every maskable source of orders 1 to 21 alone, vector follows the default order
		for (int i = 1; i < intc_pkg::NUM_MASKABLE; i++) begin
			exp_q.push_back(16'(intc_pkg::VEC_FIRST_PIN + 2 * (i - 1)));
			cfg <= 4'h4;
			pulse(25'h1 << i);
			drain("one source");
		end
		cfg <= 4'h3;
		exp_q.push_back(16'h0020);
		exp_q.push_back(16'h0022);
		pulse(25'h1 << 23);
		pulse(25'h1 << 22);
		pulse(25'h1 << 14);
		pulse(25'h1 << 15);
		cfg <= 4'h0;
		pulse(25'h1 << 16);
		drain("timers");
		bus_rd(intc_pkg::OFS_FLAGS, rd); check("no timer flags", rd, 32'h00000000);
		// Simultaneous requests, low group then one raised to high group
		exp_q.push_back(16'h000a);
		exp_q.push_back(16'h000e);
		exp_q.push_back(16'h001c);
		pulse(25'h1028);
		drain("default order");
		bus_wr(intc_pkg::OFS_PRIO, 32'h003fefff);
		exp_q.push_back(16'h001c);
		exp_q.push_back(16'h000a);
		pulse(25'h1008);
		drain("high first");
		// Nesting: low service blocks low, admits high
		auto_ret <= 1'b0;
		exp_q.push_back(16'h000a);
		pulse(25'h8);
		drain("low taken");
		bus_rd(intc_pkg::OFS_FLAGS, rd); check("ack clears", rd, 32'h00000000);
		pulse(25'h20);
		repeat (8) @(posedge clk);
		bus_rd(intc_pkg::OFS_STATUS, rd); check("low blocks", rd[13:7], 7'h10);
		exp_q.push_back(16'h001c);
		pulse(25'h1000);
		drain("nested");
		bus_rd(intc_pkg::OFS_STATUS, rd); check("nested state", rd[13:10], 4'b1000);
		@(posedge clk) extra_ret <= 1'b1;
		@(posedge clk) extra_ret <= 1'b0;
		auto_ret <= 1'b1;
		exp_q.push_back(16'h000e);
		repeat (4) @(posedge clk);
		@(posedge clk) extra_ret <= 1'b1;
		@(posedge clk) extra_ret <= 1'b0;
		drain("unwind");
		close_out();
	end
endmodule : vectored_interrupt_arbiter_tb_top
